// file: shared/ewc_params.svh
`ifndef EWC_PARAMS_SVH
`define EWC_PARAMS_SVH

// Register byte offsets
`define EWC_OFS_ACCESS_STATE  12'h000
`define EWC_OFS_WAIT_ENABLE   12'h004
`define EWC_OFS_DELAY_CONTROL 12'h008
`define EWC_OFS_STATUS        12'h00c

// Reset values
`define EWC_RST_ACCESS_STATE  8'hff
`define EWC_RST_WAIT_ENABLE   8'hff
`define EWC_RST_DELAY_CONTROL 8'hf3

// Delay control field positions
`define EWC_COUNT_LSB         0
`define EWC_COUNT_MSB         1
`define EWC_MODE_LO_BIT       2
`define EWC_MODE_HI_BIT       3

// Status field positions
`define EWC_STAT_BUSY_BIT     0
`define EWC_STAT_DELAY_LSB    8

// AXI responses
`define EWC_RESP_OKAY         2'b00
`define EWC_RESP_SLVERR       2'b10

`endif

// file: shared/ewc_pkg.sv
package ewc_pkg;

   // Bus cycle sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_T1,
      ST_T2,
      ST_TW,
      ST_T3
   } ewc_state_type;

   // Resolved delay mode of one access
   typedef enum logic [2:0] {
      MODE_NONE,
      MODE_PIN0,
      MODE_PROG,
      MODE_PIN1,
      MODE_AUTO
   } ewc_mode_type;

   // Access request from the CPU bus master
   typedef struct packed {
      logic       start;
      logic [2:0] area;
   } ewc_req_type;

   // Per-access timing view towards the external bus
   typedef struct packed {
      logic three_state;
      logic second_access_state;
      logic inserted_delay_state;
      logic cycle_end;
   } ewc_bus_type;

endpackage

// file: rtl/ewc_wait_ctrl.sv
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
`include "ewc_params.svh"
// Notes on behaviour
// RL1 - Per-area three-state and delay enable bits
// RL2 - Mode select bits shared by all areas
// RL3 - Decode area bits and mode into mode
// RL4 - Pin mode 0: counter idle, pin only
// RL5 - Pin mode 0: extend while pin low
// RL6 - Pin mode 1: counted states first
// RL7 - Pin mode 1: extend after last counted
// RL8 - Pin mode 1 count zero acts like 0
// RL9 - Auto mode: pin low gives counted states
// RL10 - Auto mode: never extend past count
// RL11 - Programmable mode: always counted states
// RL12 - Reset values FF, FF, F3
// RL13 - Register writes apply from next cycle
// RL14 - Two-bit count in low bits
// RL15 - Two-state areas never get delays
module ewc_wait_ctrl #(
   parameter int AREAS   = 8,
   parameter int CNT_W   = 2
) (
   input  wire logic               aclk,
   input  wire logic               aresetn,
   input  wire logic [11:0]        s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire logic [11:0]        s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   input  wire ewc_pkg::ewc_req_type req,
   output logic                    req_ready,
   input  wire logic               hold_req_n,
   output ewc_pkg::ewc_bus_type    bus
);
   import ewc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Registers and state

   logic [AREAS-1:0] area_access_state_reg;
   logic [AREAS-1:0] area_wait_enable_reg;
   logic [7:0]       delay_control_reg;
   logic             hold_meta;
   logic             hold_sync;
   ewc_state_type    state;
   ewc_mode_type     snap_mode;
   logic             snap_three;
   logic [CNT_W-1:0] snap_count;
   logic [CNT_W-1:0] wait_left;
   logic             pin_ext;
   logic [7:0]       delay_total;
   logic [7:0]       last_delay;
   logic             aw_held;
   logic             w_held;
   logic [11:0]      aw_addr;
   logic [31:0]      w_data;
   logic [3:0]       w_strb;
   logic             pin_low;
   logic             wr_fire;
   logic [CNT_W-1:0] wc_field;

   assign pin_low  = ~hold_sync;
   assign wr_fire  = aw_held && w_held && !s_axi_bvalid;
   assign wc_field = delay_control_reg[`EWC_COUNT_MSB:`EWC_COUNT_LSB]; // [RL14]

   // Mode of one area from its two bits and the shared select bits
   function automatic ewc_mode_type area_mode(input logic three, input logic en, input logic [1:0] ms);
      ewc_mode_type m;
      m = MODE_NONE;
      if (!three) begin
         m = MODE_NONE;
      end else if (!en) begin
         m = MODE_PIN0;
      end else begin
         case (ms)
            2'b00:   m = MODE_PROG;
            2'b01:   m = MODE_NONE;
            2'b10:   m = MODE_PIN1;
            default: m = MODE_AUTO;
         endcase
      end
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Hold request pin synchroniser

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_meta <= 1'b1;
         hold_sync <= 1'b1;
      end else begin
         hold_meta <= hold_req_n;
         hold_sync <= hold_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel

   assign s_axi_awready = !aw_held;
   assign s_axi_wready  = !w_held;

   // Capture address and data in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 12'h000;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end
      end
   end

   // Register update and write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         area_access_state_reg <= `EWC_RST_ACCESS_STATE; // [RL12]
         area_wait_enable_reg  <= `EWC_RST_WAIT_ENABLE;
         delay_control_reg     <= `EWC_RST_DELAY_CONTROL;
         s_axi_bvalid          <= 1'b0;
         s_axi_bresp           <= `EWC_RESP_OKAY;
      end else begin
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `EWC_RESP_OKAY;
            if (aw_addr[11:2] == `EWC_OFS_ACCESS_STATE >> 2) begin
               if (w_strb[0]) area_access_state_reg <= w_data[AREAS-1:0]; // [RL1]
            end else if (aw_addr[11:2] == `EWC_OFS_WAIT_ENABLE >> 2) begin
               if (w_strb[0]) area_wait_enable_reg <= w_data[AREAS-1:0]; // [RL1]
            end else if (aw_addr[11:2] == `EWC_OFS_DELAY_CONTROL >> 2) begin
               if (w_strb[0]) delay_control_reg <= w_data[7:0];
            end else if (aw_addr[11:2] == `EWC_OFS_STATUS >> 2) begin
               s_axi_bresp <= `EWC_RESP_OKAY; // Read-only, write ignored
            end else begin
               s_axi_bresp <= `EWC_RESP_SLVERR;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel

   assign s_axi_arready = !s_axi_rvalid;

   // One-cycle read answer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `EWC_RESP_OKAY;
      end else begin
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `EWC_RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
            if (s_axi_araddr[11:2] == `EWC_OFS_ACCESS_STATE >> 2) begin
               s_axi_rdata[AREAS-1:0] <= area_access_state_reg;
            end else if (s_axi_araddr[11:2] == `EWC_OFS_WAIT_ENABLE >> 2) begin
               s_axi_rdata[AREAS-1:0] <= area_wait_enable_reg;
            end else if (s_axi_araddr[11:2] == `EWC_OFS_DELAY_CONTROL >> 2) begin
               s_axi_rdata[7:0] <= delay_control_reg;
            end else if (s_axi_araddr[11:2] == `EWC_OFS_STATUS >> 2) begin
               s_axi_rdata[`EWC_STAT_BUSY_BIT] <= (state != ST_IDLE);
               s_axi_rdata[`EWC_STAT_DELAY_LSB +: 8] <= last_delay;
            end else begin
               s_axi_rresp <= `EWC_RESP_SLVERR;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus cycle sequencer

   assign req_ready = (state == ST_IDLE);

   // Access states; one delay state per clock
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state      <= ST_IDLE;
         snap_mode  <= MODE_NONE;
         snap_three <= 1'b0;
         snap_count <= '0;
         wait_left  <= '0;
         pin_ext    <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (req.start) begin
                  // Settings frozen for the whole cycle [RL13]
                  snap_three <= area_access_state_reg[req.area];
                  snap_mode  <= area_mode(area_access_state_reg[req.area], area_wait_enable_reg[req.area],
                                          {delay_control_reg[`EWC_MODE_HI_BIT],
                                           delay_control_reg[`EWC_MODE_LO_BIT]}); // [RL1] [RL2] [RL3]
                  snap_count <= wc_field;
                  state      <= ST_T1;
               end
            end
            ST_T1: begin
               state <= ST_T2;
            end
            ST_T2: begin
               state   <= ST_T3;
               pin_ext <= 1'b0;
               if (!snap_three) begin
                  state <= ST_IDLE; // [RL15]
               end else begin
                  case (snap_mode)
                     MODE_PIN0: begin
                        if (pin_low) begin // [RL4] [RL5]
                           state     <= ST_TW;
                           wait_left <= '0;
                           pin_ext   <= 1'b1;
                        end
                     end
                     MODE_PROG: begin
                        if (snap_count != '0) begin // [RL11]
                           state     <= ST_TW;
                           wait_left <= snap_count;
                        end
                     end
                     MODE_PIN1: begin
                        if (snap_count != '0) begin // [RL6]
                           state     <= ST_TW;
                           wait_left <= snap_count;
                           pin_ext   <= 1'b1;
                        end else if (pin_low) begin // [RL8]
                           state     <= ST_TW;
                           wait_left <= '0;
                           pin_ext   <= 1'b1;
                        end
                     end
                     MODE_AUTO: begin
                        if (pin_low && snap_count != '0) begin // [RL9]
                           state     <= ST_TW;
                           wait_left <= snap_count;
                        end
                     end
                     default: begin
                        state <= ST_T3;
                     end
                  endcase
               end
            end
            ST_TW: begin
               if (wait_left > 1) begin
                  wait_left <= wait_left - 1'b1;
               end else if (pin_ext && pin_low) begin
                  wait_left <= '0; // [RL5] [RL7]
               end else begin
                  state <= ST_T3; // [RL10]
               end
            end
            ST_T3: begin
               state <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Delay states inserted in the last finished access
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         delay_total <= 8'h00;
         last_delay  <= 8'h00;
      end else if (state == ST_T1) begin
         delay_total <= 8'h00;
      end else if (state == ST_TW && delay_total != 8'hff) begin
         delay_total <= delay_total + 8'h01;
      end else if (bus.cycle_end) begin
         last_delay <= delay_total;
      end
   end

   // Bus timing outputs
   assign bus.three_state          = snap_three && (state != ST_IDLE);
   assign bus.second_access_state  = (state == ST_T2);
   assign bus.inserted_delay_state = (state == ST_TW);
   assign bus.cycle_end            = (state == ST_T3) || (state == ST_T2 && !snap_three);

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   two_state_nodelay_a: assert property ((state == ST_T2 && !snap_three) |=> state == ST_IDLE) // [RL15]
      else $error("two-state access was lengthened");
   nowait_mode_a: assert property ((state == ST_T2 && snap_three && snap_mode == MODE_NONE) |=> state == ST_T3) // [RL3]
      else $error("no-wait mode inserted a delay");
   pin0_release_a: assert property ((state == ST_T2 && snap_mode == MODE_PIN0 && !pin_low) |=> state == ST_T3) // [RL4]
      else $error("pin mode 0 delayed without pin");
   pin_hold_a: assert property ((state == ST_TW && pin_ext && wait_left <= 1 && pin_low) |=> state == ST_TW) // [RL5]
      else $error("held pin did not extend access");
   prog_count_a: assert property ((state == ST_T2 && snap_three && snap_mode == MODE_PROG && snap_count == 2'd3)
                                  |=> state == ST_TW [*3] ##1 state == ST_T3) // [RL11]
      else $error("programmable count not honoured");
   pin1_count_a: assert property ((state == ST_T2 && snap_three && snap_mode == MODE_PIN1 && snap_count == 2'd2)
                                  |=> state == ST_TW [*2]) // [RL6]
      else $error("pin mode 1 counted states missing");
   auto_skip_a: assert property ((state == ST_T2 && snap_three && snap_mode == MODE_AUTO && !pin_low)
                                 |=> state == ST_T3) // [RL9]
      else $error("auto mode delayed with pin high");
   auto_noext_a: assert property ((state == ST_T2 && snap_three && snap_mode == MODE_AUTO && pin_low && snap_count == 2'd1)
                                  |=> state == ST_TW ##1 state == ST_T3) // [RL10]
      else $error("auto mode extended past count");
   cfg_frozen_a: assert property ((state != ST_IDLE && state != ST_T1) |-> $stable(snap_mode) && $stable(snap_three)) // [RL13]
      else $error("settings changed inside a bus cycle");
   reset_values_a: assert property (!$past(aresetn) |-> area_access_state_reg == 8'hff && area_wait_enable_reg == 8'hff
                                    && delay_control_reg == 8'hf3) // [RL12]
      else $error("wrong register reset values");

   prog_seen_c: cover property (state == ST_T2 && snap_mode == MODE_PROG ##1 state == ST_TW);
   pin_ext_c: cover property (state == ST_TW && pin_ext && wait_left == '0);
   auto_seen_c: cover property (state == ST_T2 && snap_mode == MODE_AUTO && pin_low);
   two_state_c: cover property (state == ST_T2 && !snap_three);

endmodule

// file: dv/ewc_ext_device.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////
// Slow external device: keeps the hold request low while not ready,
// frees it a set number of cycles into its own access
module ewc_ext_device (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [1:0]          slow,
   input  wire ewc_pkg::ewc_bus_type bus,
   output logic                     hold_req_n
);
   import ewc_pkg::*;

   logic [2:0] elapsed;

   // Re-arm between accesses, release once the latency has run out
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         elapsed    <= 3'h0;
         hold_req_n <= 1'b1;
      end else if (!bus.three_state || bus.cycle_end) begin
         elapsed    <= 3'h0;
         hold_req_n <= (slow == 2'h0);
      end else if (elapsed + 3'h1 >= {1'b0, slow}) begin
         hold_req_n <= 1'b1;
      end else begin
         elapsed <= elapsed + 3'h1;
      end
   end
endmodule

// file: dv/ewc_wait_ctrl_bench.sv
`timescale 1ns/100ps
`include "ewc_params.svh"
////////////////////////////////////////////////////////////
module ewc_wait_ctrl_bench;
   import ewc_pkg::*;

   logic        aclk, aresetn, hold_req_n, req_ready, ts;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d, cfg;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, slow, r, m, c;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [7:0]  ast, wce;
   logic [2:0]  a;
   ewc_req_type req;
   ewc_bus_type bus;
   int          n_errors, check_count, cyc, tw, s, n;

   ewc_wait_ctrl ewc_wait_ctrl_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .req, .req_ready, .hold_req_n, .bus);
   ewc_ext_device ewc_ext_device_inst (.aclk, .aresetn, .slow, .bus, .hold_req_n);

   // Clock
   always #2 aclk = ~aclk;

   ////////////////////////////////////////////////////////////
   // Compare and count
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Delay states expected for one access
   function automatic int exp_waits(logic t3, logic we, logic [1:0] md, logic [1:0] ct, int sl);
      if (!t3) return 0;
      if (!we) return (sl > 0) ? sl + 1 : 0;
      case (md)
         2'b00: return ct;
         2'b01: return 0;
         2'b10: return (sl > 0 && sl >= ct) ? sl + 1 : ct;
         default: return (sl > 0) ? ct : 0;
      endcase
   endfunction

   // Register write, address and data offered together
   task automatic wr(input logic [11:0] ad, input logic [31:0] dt, output logic [1:0] rs);
      logic ta, tk, aw_on, w_on;
      @(posedge aclk);
      s_axi_awaddr  <= ad;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= dt;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      aw_on = 1'b1;
      w_on  = 1'b1;
      while (aw_on || w_on) begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tk = s_axi_wvalid && s_axi_wready;
         @(posedge aclk);
         aw_on = aw_on && !ta;
         w_on  = w_on && !tk;
         s_axi_awvalid <= aw_on;
         s_axi_wvalid  <= w_on;
      end
      do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
      rs = s_axi_bresp;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask

   // Register read
   task automatic rd(input logic [11:0] ad, output logic [31:0] dt, output logic [1:0] rs);
      @(posedge aclk);
      s_axi_araddr  <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(negedge aclk); while (s_axi_arready !== 1'b1);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
      dt = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask

   // One bus access, counting cycles and delay states
   task automatic access(input logic [2:0] ar, output int cy, output int nw, output logic t3);
      @(posedge aclk);
      req <= '{start: 1'b1, area: ar};
      @(posedge aclk);
      req.start <= 1'b0;
      cy = 0;
      nw = 0;
      t3 = 1'b0;
      while (cy < 40) begin
         @(negedge aclk);
         cy++;
         if (cy == 1) t3 = bus.three_state;
         if (cy == 1) chk("req_ready", req_ready, 1'b0);
         if (cy == 2) chk("second_access_state", bus.second_access_state, 1'b1);
         if (bus.inserted_delay_state === 1'b1) nw++;
         if (bus.cycle_end === 1'b1) break;
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////
   // Watchdog
   initial begin
      repeat (6000) @(posedge aclk);
      n_errors++;
      tally_and_finish;
   end

   // Main sequence
   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      req = '0;
      slow = 2'h0;
      s_axi_awaddr = '0;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'hf;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = '0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      void'($urandom(32'he60c207c));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`EWC_OFS_ACCESS_STATE, d, r);
      chk("area_access_state_reg", d, 32'hff);
      rd(`EWC_OFS_WAIT_ENABLE, d, r);
      chk("area_wait_enable_reg", d, 32'hff);
      rd(`EWC_OFS_DELAY_CONTROL, d, r);
      chk("delay_control_reg", d, 32'hf3);
      wr(12'h010, 32'h0, r);
      chk("bresp", r, `EWC_RESP_SLVERR);
      rd(12'h010, d, r);
      chk("rresp", r, `EWC_RESP_SLVERR);
      $display("test reset_and_map done");
      // Area 0 turned two-state while its access runs
      fork
         access(3'h0, cyc, tw, ts);
         wr(`EWC_OFS_ACCESS_STATE, 32'hfe, r);
      join
      chk("delay_states", tw, 3);
      chk("access_cycles", cyc, 6);
      access(3'h0, cyc, tw, ts);
      chk("access_cycles", cyc, 2);
      $display("test write_timing done");
      // Corner cases: pin mode 1 with two counted states, auto mode with one, slow device
      wr(`EWC_OFS_ACCESS_STATE, 32'hff, r);
      wr(`EWC_OFS_WAIT_ENABLE, 32'hff, r);
      slow <= 2'h2;
      for (int k = 0; k < 2; k++) begin
         wr(`EWC_OFS_DELAY_CONTROL, k ? 32'h0d : 32'h0a, r);
         chk("bresp", r, `EWC_RESP_OKAY);
         access(3'h7, cyc, tw, ts);
         chk("delay_states", tw, k ? 1 : 3);
      end
      $display("test corner_modes done");
      // Random settings, every mode in turn, two accesses back to back
      for (int i = 0; i < 24; i++) begin
         m = i[1:0];
         c = 2'($urandom);
         s = $urandom % 3;
         ast = 8'($urandom);
         wce = 8'($urandom);
         a = 3'($urandom);
         cfg = {24'h0, 4'($urandom), m, c};
         wr(`EWC_OFS_ACCESS_STATE, {24'h0, ast}, r);
         wr(`EWC_OFS_WAIT_ENABLE, {24'h0, wce}, r);
         wr(`EWC_OFS_DELAY_CONTROL, cfg, r);
         chk("bresp", r, `EWC_RESP_OKAY);
         rd(`EWC_OFS_DELAY_CONTROL, d, r);
         chk("delay_control_reg", d, cfg);
         rd(`EWC_OFS_WAIT_ENABLE, d, r);
         chk("area_wait_enable_reg", d, {24'h0, wce});
         chk("rresp", r, `EWC_RESP_OKAY);
         slow <= 2'(s);
         repeat (2) begin
            access(a, cyc, tw, ts);
            n = exp_waits(ast[a], wce[a], m, c, s);
            chk("three_state", ts, ast[a]);
            chk("delay_states", tw, n);
            chk("access_cycles", cyc, ast[a] ? 3 + n : 2);
         end
         // Status shows idle and the delay states of the last access
         rd(`EWC_OFS_STATUS, d, r);
         chk("status", d, {16'h0, 8'(n), 8'h00});
      end
      $display("test random_modes done");
      tally_and_finish;
   end
endmodule
